/* File: hdl/mac_sec_pkg.sv */
// Constants shared by the security and receive control block.
// Assumes a 32-bit classic Wishbone register bus with 8-bit registers in lane 0.
package mac_sec_pkg;
   // ==========================================================================
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_RX_MODE     = 10'h000;  // Receive mode field
   localparam logic [9:0] IDX_RX_FILTER   = 10'h00d;  // Frame type filter and flush
   localparam logic [9:0] IDX_TRIG_BEACON = 10'h01a;
   localparam logic [9:0] IDX_TRIG_NORMAL = 10'h01b;
   localparam logic [9:0] IDX_TRIG_SLOT1  = 10'h01c;
   localparam logic [9:0] IDX_TRIG_SLOT2  = 10'h01d;
   localparam logic [9:0] IDX_SEC_PRI     = 10'h02c;  // security_control_primary
   localparam logic [9:0] IDX_SEC_SEC     = 10'h02d;  // security_control_secondary
   localparam logic [9:0] IDX_INT_STATUS  = 10'h031;
   localparam logic [9:0] IDX_SEC_TER     = 10'h037;  // security_control_tertiary
   localparam logic [9:0] IDX_KEY_BASE    = 10'h280;  // Normal buffer key slot
   localparam logic [9:0] IDX_KEY_SLOT1   = 10'h290;
   localparam logic [9:0] IDX_KEY_SLOT2   = 10'h2a0;  // Shared by slot2 and beacon
   localparam logic [9:0] IDX_KEY_RX      = 10'h2b0;
   localparam logic [9:0] IDX_RXBUF_BASE  = 10'h300;
   // ==========================================================================
   // Field positions
   localparam int TRIG_GO_BIT     = 0;
   localparam int TRIG_SEC_BIT    = 1;
   localparam int PRI_NTX_LSB     = 0;
   localparam int PRI_RX_LSB      = 3;
   localparam int PRI_START_BIT   = 6;
   localparam int PRI_IGNORE_BIT  = 7;
   localparam int SEC_ENCDIS_BIT  = 0;
   localparam int SEC_DECDIS_BIT  = 1;
   localparam int SEC_SNIFF_BIT   = 3;
   localparam int SEC_BCN_LSB     = 4;
   localparam int TER_G1_LSB      = 0;
   localparam int TER_G2_LSB      = 3;
   localparam int TER_UPPER_LAYER_ENCRYPT_BIT   = 6;
   localparam int TER_UPPER_LAYER_DECRYPT_BIT   = 7;
   localparam int FLT_FLUSH_BIT   = 0;
   localparam int FLT_CMD_BIT     = 1;
   localparam int FLT_DATA_BIT    = 2;
   localparam int FLT_BCN_BIT     = 3;
   localparam int ST_RECEIVE_GOOD_IRQ_BIT     = 3;
   localparam int ST_SEC_BIT      = 4;
   // ==========================================================================
   // Encodings
   typedef enum logic [2:0] {
      CIPH_NONE, CIPH_CTR, CIPH_CCM128, CIPH_CCM64, CIPH_CCM32,
      CIPH_CBC128, CIPH_CBC64, CIPH_CBC32
   } cipher_t;
   localparam logic [1:0] MODE_ADDR    = 2'h0;
   localparam logic [1:0] MODE_PROMISC = 2'h1;
   localparam logic [2:0] FT_BEACON    = 3'h0;
   localparam logic [2:0] FT_DATA      = 3'h1;
   localparam logic [2:0] FT_CMD       = 3'h3;
   localparam int FC_SEC_BIT   = 3;
   localparam int FC_ACK_BIT   = 5;
   localparam int FC_PANC_BIT  = 6;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [15:0] CRC_POLY = 16'h8408;  // Reflected x^16+x^12+x^5+1
   localparam logic [15:0] BCAST    = 16'hffff;
endpackage

/* File: hdl/mac_security_rx_control.sv */
// Security control and receive path control of a low-rate wireless MAC.
// Assumes baseband bytes synchronous to clock and a classic Wishbone master.
// Overview of operation
// - Sixteen-byte key slots: normal 0x280, slot1 0x290, slot2 and beacon 0x2A0.
// - Cipher fields are 3 bits: none, counter, three CCM, three CBC-MAC.
// - Beacon mode in secondary bits 6-4; slot2 and slot1 in tertiary 5-3, 2-0.
// - Primary holds normal transmit mode bits 2-0, receive mode bits 5-3.
// - Encrypted transmit completion uses the same status flags as plain frames.
// - Primary bit 7 write abandons pending decryption; the bit reads zero.
// - Primary bit 6 write starts decryption of the pending frame.
// - Decrypt-disable suppresses the security flag for secured headers.
// - Encrypt-disable sends frames plain despite security-enable.
// - Tertiary bits 7 and 6 trigger upper-layer decrypt and encrypt.
// - Receive mode selects address recognition, promiscuous or error acceptance.
// - Checksum updates per byte and is judged after the whole frame.
// - In address-recognition mode only, an accepted frame asking acknowledgement requests an automatic ACK.
// - Buffer holds length, header, payload, checksum, quality, strength.
// - Three-bit filter may restrict to command, beacon or data frames.
// - Filtered frame with good checksum sets receive-OK status bit 3.
// - Buffer flushes after first and last byte read, or flush write.
// - Secured header sets security status bit 4 after its last byte.
// - Successful decryption raises receive-OK to mark completion.
// - Trigger bit 1 is security request; bit 0 launches and self-clears.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module mac_security_rx_control #(
   parameter int BUF_DEPTH = 130
) (
   // System
   input  wire logic        clock,
   input  wire logic        rst,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Baseband receive stream
   input  wire logic        bbValid,
   input  wire logic        bbFirst,
   input  wire logic [7:0]  bbData,
   // Own addressing
   input  wire logic [15:0] ownPanId,
   input  wire logic [15:0] ownShortAddr,
   // Transmit logic
   input  wire logic [2:0]  txDone,
   output logic      [3:0]  txStart,
   output logic      [3:0]  txSecure,
   output logic             upperEncrypt,
   output logic             upperDecrypt,
   output logic             ackRequest,
   // Cipher engine
   input  wire logic [5:0]  keyIdx,
   output logic      [7:0]  keyByte,
   output logic             decStart,
   input  wire logic        decDone,
   // Mode levels
   output logic      [2:0]  rxCipherMode,
   output logic             snifferEnable
);
   // ==========================================================================
   // Types and helpers
   typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_TAIL, RX_EVAL, RX_WAITSEC, RX_DECRYPT, RX_HOLD} rxst_t;

   // One byte of the reflected frame checksum
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ mac_sec_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // MAC header length from the two frame control bytes
   function automatic logic [7:0] hdrLen(input logic [7:0] fc0, input logic [7:0] fc1);
      logic [7:0] n;
      n = 8'h03;
      if (fc1[3:2] == 2'h2) n = n + 8'h04;
      if (fc1[3:2] == 2'h3) n = n + 8'h0a;
      if (fc1[7:6] == 2'h2) n = n + 8'h02;
      if (fc1[7:6] == 2'h3) n = n + 8'h08;
      if (fc1[7:6] != 2'h0 && !(fc0[mac_sec_pkg::FC_PANC_BIT] && fc1[3:2] != 2'h0)) n = n + 8'h02;
      return n;
   endfunction

   // ==========================================================================
   // State
   logic [7:0]  rxBuf_ff [BUF_DEPTH];
   logic [7:0]  keyMem_ff [64];
   rxst_t       rxState_ff;
   logic [7:0]  rxCnt_ff;
   logic [15:0] crc_ff;
   logic [1:0]  rxMode_ff;
   logic [2:0]  typeFilter_ff;
   logic [4:0]  status_ff;
   logic [3:0]  secEn_ff;
   logic [2:0]  ntxMode_ff, bcnMode_ff, g1Mode_ff, g2Mode_ff, rxMode3_ff;
   logic        encDisable_ff, decDisable_ff, sniff_ff;
   logic        secPending_ff, secGo_ff, secSkip_ff;
   logic        readFirst_ff, readLast_ff;
   logic        ack_ff;
   logic [31:0] rdat_ff;

   // ==========================================================================
   // Bus decode: answer one cycle after request, commit on the acked edge
   logic [9:0] idx;
   logic       commit, wrEn, rdEn, flushReq, bufIdx, keyIdxHit;
   logic [7:0] wb, bufOff, lastOff;
   logic       frameEnd, hdrEnd, accepted, typeOk, addrOk, crcGood;

   assign idx       = adr_i[11:2];
   assign commit    = cyc_i && stb_i && ack_ff;
   assign wrEn      = commit && we_i && sel_i[0];
   assign rdEn      = commit && !we_i;
   assign wb        = dat_i[7:0];
   assign bufIdx    = (idx[9:8] == 2'h3);
   assign keyIdxHit = (idx[9:6] == 4'ha);
   assign bufOff    = idx[7:0];
   assign lastOff   = rxBuf_ff[0] + 8'h02;  // Strength byte sits after quality
   assign flushReq  = (wrEn && idx == mac_sec_pkg::IDX_RX_FILTER && wb[mac_sec_pkg::FLT_FLUSH_BIT]) ||
                      (rxState_ff == RX_HOLD && readFirst_ff && readLast_ff);

   // Register read mux
   function automatic logic [7:0] regRead(input logic [9:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         mac_sec_pkg::IDX_RX_MODE:     v = {6'h00, rxMode_ff};
         mac_sec_pkg::IDX_RX_FILTER:   v = {4'h0, typeFilter_ff, 1'b0};
         mac_sec_pkg::IDX_TRIG_BEACON: v = {6'h00, secEn_ff[3], 1'b0};
         mac_sec_pkg::IDX_TRIG_NORMAL: v = {6'h00, secEn_ff[0], 1'b0};
         mac_sec_pkg::IDX_TRIG_SLOT1:  v = {6'h00, secEn_ff[1], 1'b0};
         mac_sec_pkg::IDX_TRIG_SLOT2:  v = {6'h00, secEn_ff[2], 1'b0};
         mac_sec_pkg::IDX_SEC_PRI:     v = {2'h0, rxMode3_ff, ntxMode_ff};  // Trigger bits read zero
         mac_sec_pkg::IDX_SEC_SEC:     v = {1'b0, bcnMode_ff, sniff_ff, 1'b0, decDisable_ff, encDisable_ff};
         mac_sec_pkg::IDX_SEC_TER:     v = {2'h0, g2Mode_ff, g1Mode_ff};
         mac_sec_pkg::IDX_INT_STATUS:  v = {3'h0, status_ff};
         default: begin
            if (a[9:8] == 2'h3 && a[7:0] < BUF_DEPTH) begin
               v = rxBuf_ff[a[7:0]];
            end
         end
      endcase
      return v;
   endfunction

   // Acknowledge and read data; unmapped reads return zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff <= cyc_i && stb_i && !ack_ff;
         if (cyc_i && stb_i && !ack_ff && !we_i) begin
            rdat_ff <= {24'h000000, regRead(idx)};
         end
      end
   end
   assign ack_o = ack_ff;
   assign dat_o = rdat_ff;

   // ==========================================================================
   // Configuration registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rxMode_ff     <= 2'h0;
         typeFilter_ff <= 3'h0;
         secEn_ff      <= 4'h0;
         ntxMode_ff    <= 3'h0;
         rxMode3_ff    <= 3'h0;
         bcnMode_ff    <= 3'h0;
         g1Mode_ff     <= 3'h0;
         g2Mode_ff     <= 3'h0;
         encDisable_ff <= 1'b0;
         decDisable_ff <= 1'b0;
         sniff_ff      <= 1'b0;
      end else if (wrEn) begin
         unique case (idx)
            mac_sec_pkg::IDX_RX_MODE:     rxMode_ff <= wb[1:0];
            mac_sec_pkg::IDX_RX_FILTER:   typeFilter_ff <= wb[3:1];
            mac_sec_pkg::IDX_TRIG_NORMAL: secEn_ff[0] <= wb[mac_sec_pkg::TRIG_SEC_BIT];
            mac_sec_pkg::IDX_TRIG_SLOT1:  secEn_ff[1] <= wb[mac_sec_pkg::TRIG_SEC_BIT];
            mac_sec_pkg::IDX_TRIG_SLOT2:  secEn_ff[2] <= wb[mac_sec_pkg::TRIG_SEC_BIT];
            mac_sec_pkg::IDX_TRIG_BEACON: secEn_ff[3] <= wb[mac_sec_pkg::TRIG_SEC_BIT];
            mac_sec_pkg::IDX_SEC_PRI: begin
               ntxMode_ff <= wb[mac_sec_pkg::PRI_NTX_LSB +: 3];
               rxMode3_ff <= wb[mac_sec_pkg::PRI_RX_LSB +: 3];
            end
            mac_sec_pkg::IDX_SEC_SEC: begin
               bcnMode_ff    <= wb[mac_sec_pkg::SEC_BCN_LSB +: 3];
               sniff_ff      <= wb[mac_sec_pkg::SEC_SNIFF_BIT];
               decDisable_ff <= wb[mac_sec_pkg::SEC_DECDIS_BIT];
               encDisable_ff <= wb[mac_sec_pkg::SEC_ENCDIS_BIT];
            end
            mac_sec_pkg::IDX_SEC_TER: begin
               g1Mode_ff <= wb[mac_sec_pkg::TER_G1_LSB +: 3];
               g2Mode_ff <= wb[mac_sec_pkg::TER_G2_LSB +: 3];
            end
            default: ;
         endcase
      end
   end
   assign rxCipherMode  = rxMode3_ff;
   assign snifferEnable = sniff_ff;

   // Key memory: four sixteen-byte slots, write-only to software for secrecy
   always_ff @(posedge clock) begin
      if (wrEn && keyIdxHit) begin
         keyMem_ff[idx[5:0]] <= wb;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) keyByte <= 8'h00;
      else keyByte <= keyMem_ff[keyIdx];
   end

   // ==========================================================================
   // Transmit triggers: one-cycle launch pulses with the security request
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         txStart      <= 4'h0;
         txSecure     <= 4'h0;
         upperEncrypt <= 1'b0;
         upperDecrypt <= 1'b0;
      end else begin
         txStart      <= 4'h0;  // Launch bit clears itself
         upperEncrypt <= 1'b0;
         upperDecrypt <= 1'b0;
         for (int b = 0; b < 4; b++) begin
            if (wrEn && idx == (b == 3 ? mac_sec_pkg::IDX_TRIG_BEACON : mac_sec_pkg::IDX_TRIG_NORMAL + 10'(b)) &&
                wb[mac_sec_pkg::TRIG_GO_BIT]) begin
               txStart[b]  <= 1'b1;
               txSecure[b] <= wb[mac_sec_pkg::TRIG_SEC_BIT] && !encDisable_ff;
            end
         end
         if (wrEn && idx == mac_sec_pkg::IDX_SEC_TER) begin
            upperDecrypt <= wb[mac_sec_pkg::TER_UPPER_LAYER_DECRYPT_BIT];
            upperEncrypt <= wb[mac_sec_pkg::TER_UPPER_LAYER_ENCRYPT_BIT];
         end
      end
   end

   // ==========================================================================
   // Receive classification
   assign hdrEnd   = (rxState_ff == RX_DATA) && bbValid && rxCnt_ff > 8'h02 &&
                     rxCnt_ff == hdrLen(rxBuf_ff[1], rxBuf_ff[2]);
   assign frameEnd = (rxState_ff == RX_TAIL) && bbValid && rxCnt_ff == lastOff;
   assign crcGood  = (crc_ff == 16'h0000);  // Residue over frame plus checksum
   always_comb begin
      typeOk = (typeFilter_ff == 3'h0) ||
               (typeFilter_ff[mac_sec_pkg::FLT_CMD_BIT - 1] && rxBuf_ff[1][2:0] == mac_sec_pkg::FT_CMD) ||
               (typeFilter_ff[mac_sec_pkg::FLT_DATA_BIT - 1] && rxBuf_ff[1][2:0] == mac_sec_pkg::FT_DATA) ||
               (typeFilter_ff[mac_sec_pkg::FLT_BCN_BIT - 1] && rxBuf_ff[1][2:0] == mac_sec_pkg::FT_BEACON);
      addrOk = (rxBuf_ff[1][2:0] == mac_sec_pkg::FT_BEACON) || (rxBuf_ff[2][3:2] == 2'h0) ||
               (({rxBuf_ff[5], rxBuf_ff[4]} == ownPanId || {rxBuf_ff[5], rxBuf_ff[4]} == mac_sec_pkg::BCAST) &&
                (rxBuf_ff[2][3:2] == 2'h3 || {rxBuf_ff[7], rxBuf_ff[6]} == ownShortAddr ||
                 {rxBuf_ff[7], rxBuf_ff[6]} == mac_sec_pkg::BCAST));
      if (rxMode_ff[1]) accepted = 1'b1;  // Error mode keeps every detected frame
      else accepted = crcGood && typeOk && (rxMode_ff == mac_sec_pkg::MODE_PROMISC || addrOk);
   end

   // Receive sequencer and buffer fill
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rxState_ff    <= RX_IDLE;
         rxCnt_ff      <= 8'h00;
         crc_ff        <= mac_sec_pkg::CRC_INIT;
         secPending_ff <= 1'b0;
         decStart      <= 1'b0;
         ackRequest    <= 1'b0;
      end else begin
         decStart   <= 1'b0;
         ackRequest <= 1'b0;
         if (flushReq) begin
            rxState_ff    <= RX_IDLE;
            secPending_ff <= 1'b0;
         end else begin
            unique case (rxState_ff)
               RX_IDLE: if (bbValid && bbFirst) begin
                  rxBuf_ff[0]   <= bbData;
                  rxCnt_ff      <= 8'h01;
                  crc_ff        <= mac_sec_pkg::CRC_INIT;
                  secPending_ff <= 1'b0;
                  rxState_ff    <= (bbData == 8'h00) ? RX_TAIL : RX_DATA;
               end
               RX_DATA: if (bbValid) begin
                  rxBuf_ff[rxCnt_ff] <= bbData;
                  crc_ff             <= crcByte(crc_ff, bbData);
                  rxCnt_ff           <= rxCnt_ff + 8'h01;
                  if (hdrEnd && rxBuf_ff[1][mac_sec_pkg::FC_SEC_BIT] && !decDisable_ff) begin
                     secPending_ff <= 1'b1;
                  end
                  if (rxCnt_ff == rxBuf_ff[0]) rxState_ff <= RX_TAIL;
               end
               RX_TAIL: if (bbValid) begin
                  rxBuf_ff[rxCnt_ff] <= bbData;  // Quality then strength
                  rxCnt_ff           <= rxCnt_ff + 8'h01;
                  if (frameEnd) rxState_ff <= RX_EVAL;
               end
               RX_EVAL: begin
                  if (!accepted) begin
                     rxState_ff <= RX_IDLE;  // Rejected frames are dropped silently
                  end else begin
                     if (rxMode_ff == mac_sec_pkg::MODE_ADDR && rxBuf_ff[1][mac_sec_pkg::FC_ACK_BIT]) begin
                        ackRequest <= 1'b1;
                     end
                     rxState_ff <= secPending_ff ? RX_WAITSEC : RX_HOLD;
                  end
               end
               RX_WAITSEC: begin
                  if (secSkip_ff) rxState_ff <= RX_HOLD;
                  else if (secGo_ff) begin
                     decStart   <= 1'b1;
                     rxState_ff <= RX_DECRYPT;
                  end
               end
               RX_DECRYPT: if (decDone) rxState_ff <= RX_HOLD;
               RX_HOLD: ;
               default: rxState_ff <= RX_IDLE;
            endcase
         end
      end
   end

   // Host decryption commands are latched until the held frame consumes them
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         secGo_ff   <= 1'b0;
         secSkip_ff <= 1'b0;
      end else if (flushReq || rxState_ff == RX_IDLE || (rxState_ff == RX_WAITSEC && (secGo_ff || secSkip_ff))) begin
         secGo_ff   <= 1'b0;
         secSkip_ff <= 1'b0;
      end else if (wrEn && idx == mac_sec_pkg::IDX_SEC_PRI && secPending_ff) begin
         secSkip_ff <= secSkip_ff | wb[mac_sec_pkg::PRI_IGNORE_BIT];
         secGo_ff   <= secGo_ff | wb[mac_sec_pkg::PRI_START_BIT];
      end
   end

   // First and last byte reads while a frame is held
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readFirst_ff <= 1'b0;
         readLast_ff  <= 1'b0;
      end else if (rxState_ff != RX_HOLD || flushReq) begin
         readFirst_ff <= 1'b0;
         readLast_ff  <= 1'b0;
      end else if (rdEn && bufIdx) begin
         if (bufOff == 8'h00) readFirst_ff <= 1'b1;
         if (bufOff == lastOff) readLast_ff <= 1'b1;
      end
   end

   // ==========================================================================
   // Status: sticky; a read clears only the flags it returned, so a late event survives; set wins
   logic [4:0] statSet;
   assign statSet = {hdrEnd && rxBuf_ff[1][mac_sec_pkg::FC_SEC_BIT] && !decDisable_ff,
                     (rxState_ff == RX_EVAL && accepted && !secPending_ff) ||
                     (rxState_ff == RX_WAITSEC && secSkip_ff) ||
                     (rxState_ff == RX_DECRYPT && decDone),
                     txDone};  // Same flags for plain and encrypted sends
   always_ff @(posedge clock or posedge rst) begin
      if (rst) status_ff <= 5'h00;
      else if (rdEn && idx == mac_sec_pkg::IDX_INT_STATUS) status_ff <= (status_ff & ~rdat_ff[4:0]) | statSet;
      else status_ff <= status_ff | statSet;
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_launch_selfclear: assert property (txStart[0] |=> !txStart[0]) else $error("launch stuck");
   a_enc_disable: assert property ((|(txStart & txSecure)) |-> !$past(encDisable_ff))
      else $error("secured send while disabled");
   a_dec_disable: assert property ($rose(status_ff[mac_sec_pkg::ST_SEC_BIT]) |-> !$past(decDisable_ff))
      else $error("security flag while disabled");
   a_hold_secured: assert property (rxState_ff == RX_WAITSEC && !secSkip_ff |=> !$rose(status_ff[3]))
      else $error("secured frame reported early");
   a_dec_start: assert property (decStart |-> $past(rxState_ff == RX_WAITSEC && secGo_ff && !secSkip_ff))
      else $error("decrypt start without command");
   a_ignore_skip: assert property (rxState_ff == RX_WAITSEC && secSkip_ff && !flushReq |=> rxState_ff == RX_HOLD
      && !decStart) else $error("ignore did not skip");
   a_flush_empty: assert property (flushReq |=> rxState_ff == RX_IDLE) else $error("flush ignored");
   a_receive_good_irq_good: assert property (rxState_ff == RX_EVAL && !rxMode_ff[1] && !crcGood |=> rxState_ff == RX_IDLE)
      else $error("bad checksum accepted");
   a_ack_accepted: assert property (ackRequest |-> $past(rxState_ff == RX_EVAL && accepted))
      else $error("ack for rejected frame");
   a_pri_trig_zero: assert property (ack_o && !we_i && idx == mac_sec_pkg::IDX_SEC_PRI |-> dat_o[7:6] == 2'h0)
      else $error("trigger bits read back");

   c_good_frame: cover property (rxState_ff == RX_EVAL && accepted ##1 rxState_ff == RX_HOLD);
   c_secured: cover property (rxState_ff == RX_DECRYPT ##[1:50] rxState_ff == RX_HOLD);
   c_flush_reads: cover property (rxState_ff == RX_HOLD && readFirst_ff && readLast_ff);
   c_secure_send: cover property (txStart[0] && txSecure[0]);
endmodule

/* File: tb/host_model.sv */
// Host side model: issues classic Wishbone single cycles into the block.
// Assumes the block answers each request with a one-cycle ack.
`timescale 1ns/1ps
module host_model (
   // System
   input  wire logic        clock,
   // Bus
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic      [11:0] adr,
   output logic      [3:0]  sel,
   output logic      [31:0] dat,
   input  wire logic [31:0] rdat,
   input  wire logic        ack
);
   // ==========================================================
   // Transfer task
   initial {cyc, stb, we, adr, sel, dat} = '0;
   // Request held until ack is seen at an edge; only the bench watchdog ends a wait on a dead slave
   task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clock);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, idx, 2'b00, 4'h1, 24'h0, wd};
      do @(posedge clock); while (ack !== 1'b1);
      rd = rdat[7:0];
      {cyc, stb, we} <= 3'b000;
      @(posedge clock);  // Bus stays idle for one cycle
   endtask
endmodule

/* File: tb/tb_mac_security_rx_control.sv */
// Self-checking bench of the security and receive control block.
// Assumes host_model as bus master and a hand-driven baseband stream.
`timescale 1ns/1ps
module tb_mac_security_rx_control;
   // ==========================================================
   // Signals
   logic clock = 1'b0, rst = 1'b1, bbValid = 1'b0, bbFirst = 1'b0, decDone = 1'b0, decStart, cyc_i, stb_i, we_i, ack_o;
   logic ackRequest, upperEncrypt, upperDecrypt;
   logic [7:0] bbData = 8'h00, keyByte;
   logic [5:0] keyIdx = 6'h10;  // First byte of the slot1 key
   logic [11:0] adr_i;
   logic [3:0] sel_i, txStart, txSecure;
   logic [31:0] dat_i, dat_o;
   logic [2:0] rxCipherMode, txDone = 3'h0;
   logic snifferEnable;
   int badCount = 0, numChecks = 0, starts = 0, decs = 0, acks = 0, ups = 0;
   always #5 clock = ~clock;
   // Launch and decrypt pulses are counted so no single-cycle window is missed
   always @(posedge clock) begin
      starts <= starts + txStart[0];
      decs <= decs + decStart;
      acks <= acks + ackRequest;
      ups <= ups + upperEncrypt + upperDecrypt;
   end
   host_model u_host_model (.clock, .cyc(cyc_i), .stb(stb_i), .we(we_i), .adr(adr_i), .sel(sel_i), .dat(dat_i),
      .rdat(dat_o), .ack(ack_o));
   mac_security_rx_control u_mac_security_rx_control (.clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .bbValid, .bbFirst, .bbData, .ownPanId(16'h0000), .ownShortAddr(16'h0000), .txDone,
      .txStart, .txSecure, .upperEncrypt, .upperDecrypt, .ackRequest, .keyIdx, .keyByte, .decStart,
      .decDone, .rxCipherMode, .snifferEnable);
   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      logic [7:0] r;
      u_host_model.xfer(1'b1, i, d, r);
   endtask
   task automatic rdc(input logic [9:0] i, input logic [7:0] e);
      logic [7:0] r;
      u_host_model.xfer(1'b0, i, 8'h00, r);
      check(r, e);
   endtask
   // Drives one frame, length byte first, then gives the block time to judge it
   task automatic send(input logic [63:0] f);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         {bbValid, bbFirst, bbData} <= {1'b1, i == 0, f[63 - 8 * i -: 8]};
      end
      @(posedge clock);
      bbValid <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rdc(10'h005, 8'h00);
      wr(mac_sec_pkg::IDX_SEC_PRI, 8'hed);
      rdc(mac_sec_pkg::IDX_SEC_PRI, 8'h2d);
      check(rxCipherMode, 3'h5);
      wr(mac_sec_pkg::IDX_SEC_SEC, 8'h78);
      rdc(mac_sec_pkg::IDX_SEC_SEC, 8'h78);
      check(snifferEnable, 1'b1);
      wr(mac_sec_pkg::IDX_SEC_TER, 8'hea);
      rdc(mac_sec_pkg::IDX_SEC_TER, 8'h2a);
      check(ups, 2);
      wr(mac_sec_pkg::IDX_KEY_SLOT1, 8'h5a);
      rdc(mac_sec_pkg::IDX_KEY_SLOT1, 8'h00);  // Key memory is write-only
      check(keyByte, 8'h5a);
      wr(mac_sec_pkg::IDX_SEC_SEC, 8'h00);  // Sniffer back to zero
      $display("test regs done");
   endtask
   task automatic t_tx();
      wr(mac_sec_pkg::IDX_TRIG_NORMAL, 8'h03);
      rdc(mac_sec_pkg::IDX_TRIG_NORMAL, 8'h02);
      check(txSecure[0], 1'b1);
      wr(mac_sec_pkg::IDX_TRIG_BEACON, 8'h03);
      check(txSecure[3], 1'b1);
      wr(mac_sec_pkg::IDX_SEC_SEC, 8'h01);
      wr(mac_sec_pkg::IDX_TRIG_NORMAL, 8'h03);
      check(txSecure[0], 1'b0);
      txDone <= 3'h5;
      @(posedge clock);
      txDone <= 3'h0;
      rdc(mac_sec_pkg::IDX_INT_STATUS, 8'h05);
      check(starts, 2);
      wr(mac_sec_pkg::IDX_SEC_SEC, 8'h00);
      $display("test tx done");
   endtask
   // Secured data frame in error mode; header is control and sequence only
   task automatic t_secrx();
      wr(mac_sec_pkg::IDX_RX_MODE, 8'h02);
      send(64'h05_09_00_01_aa_bb_40_c0);
      rdc(mac_sec_pkg::IDX_INT_STATUS, 8'h10);
      wr(mac_sec_pkg::IDX_SEC_PRI, 8'h68);
      decDone <= 1'b1;
      @(posedge clock);
      decDone <= 1'b0;
      rdc(mac_sec_pkg::IDX_INT_STATUS, 8'h08);
      check(decs, 1);
      rdc(mac_sec_pkg::IDX_RXBUF_BASE, 8'h05);
      rdc(mac_sec_pkg::IDX_RXBUF_BASE + 10'h007, 8'hc0);  // Strength read completes the flush
      $display("test secured rx done");
   endtask
   // Address mode: a frame with a broken checksum is dropped, the good one is kept and acknowledged
   task automatic t_ackrx();
      wr(mac_sec_pkg::IDX_RX_MODE, 8'h00);
      send(64'h05_20_00_00_3b_04_40_c0);
      rdc(mac_sec_pkg::IDX_INT_STATUS, 8'h00);
      send(64'h05_20_00_00_3b_03_40_c0);
      rdc(mac_sec_pkg::IDX_INT_STATUS, 8'h08);
      check(acks, 1);
      wr(mac_sec_pkg::IDX_RX_FILTER, 8'h01);  // Flush bit
      $display("test ack rx done");
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      t_regs();
      t_tx();
      t_secrx();
      t_ackrx();
      report_and_stop();
   end
   initial begin
      #200000;
      badCount++;
      report_and_stop();
   end
endmodule
